// ==== include/spfs_regs.svh ====
// Purpose: named constants for the shared pin function select block
// Assumes: configuration bits arrive as plain ports, no register bus
// Notes: values are select codes, reset defaults of the select ports and fill constants
`ifndef SPFS_REGS_SVH
`define SPFS_REGS_SVH
`define SPFS_GENERAL_PIN_0_DEFAULT 2'h0
`define SPFS_GENERAL_PIN_0_LCD 2'h1
`define SPFS_GENERAL_PIN_0_REFRESH 2'h2
`define SPFS_DMA_CH1 2'h1
`define SPFS_DMA_CH2 2'h2
`define SPFS_DMA_CH3 2'h3
`define SPFS_DMA_CH_RESET 2'h1
`define SPFS_ZERO1 1'h0
`define SPFS_ONE1 1'h1
`define SPFS_ONES2 2'h3
`define SPFS_ZERO2 2'h0
`define SPFS_ONES3 3'h7
`endif

// ==== include/spfs_pkg.sv ====
// Purpose: types for the shared pin function select block
// Assumes: nothing
// Notes: gpio pin 0 source select
package spfs_pkg;
    typedef enum logic [2:0] {
        SPFS_G0_GPIO = 3'h1,
        SPFS_G0_LCD = 3'h2,
        SPFS_G0_REFRESH = 3'h4
    } spfs_g0_t;
endpackage

// ==== hdl/spfs_pin_mux.sv ====
// Purpose: shared pin function select for keyboard, card slot, dma and lcd pins
// Assumes: all inputs synchronous to CORE_CLK, configuration written by software
// Notes: selects are registered so pin roles switch on a clean edge
`include "spfs_regs.svh"
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - scanner off: return line 3 sampled as printer busy
// - slot A battery inputs are memory status, or speaker/status-change for io cards
// - slot B battery inputs only with scanner off; io mode gives speaker/status-change
// - drive active-low odd and even card buffer enables
// - one shared buffer direction output follows transfer direction
// - slot B card detects sampled only with scanner off, on shift lines 3,4
// - drive slot A even and odd chip selects, active low
// - slot B chip selects driven only with scanner off, on scan lines 4,5
// - external dma ack carries the ack of the programmed channel 1..3
// - external dma request routed to the programmed channel 1..3
// - general pin 0: gpio by default, lcd data 0 or refresh ack when selected
// - lcd disabled: modulation pin outputs refresh ack
// - scanner off: return line 7 sampled as printer error, active low
// - suspend switch input requests suspend or resume
// - alternative functions chosen only by configuration settings
module spfs_pin_mux
    import spfs_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // configuration from software
    input wire logic KEY_SCAN_DISABLE,
    input wire logic SLOT_A_IO_MODE,
    input wire logic SLOT_B_IO_MODE,
    input wire logic [1:0] GENERAL_PIN_0_SELECT,
    input wire logic LCD_DISABLE,
    input wire logic [1:0] DMA_CHANNEL_SELECT,
    // internal sources
    input wire logic CARD_ACCESS,
    input wire logic CARD_SLOT_B,
    input wire logic CARD_EVEN_BYTE,
    input wire logic CARD_ODD_BYTE,
    input wire logic CARD_READ,
    input wire logic [2:0] DMA_ACK_INT_N,
    input wire logic REFRESH_ACK_N,
    input wire logic GENERAL_PIN_0_OUT_INT,
    input wire logic LCD_LOWER_DATA_0,
    input wire logic LCD_MODULATION_INT,
    input wire logic [1:0] KEY_SCAN_INT,
    // pins
    input wire logic KEY_RETURN_LINE_3,
    input wire logic KEY_RETURN_LINE_7,
    input wire logic [1:0] SLOT_A_BATTERY_STATUS,
    input wire logic [3:0] KEY_SHIFT_LINES,
    input wire logic DMA_REQUEST_IN,
    input wire logic SUSPEND_SWITCH_IN,
    output logic CARD_BUFFER_ENABLES_N_ODD,
    output logic CARD_BUFFER_ENABLES_N_EVEN,
    output logic CARD_BUFFER_DIRECTION,
    output logic SLOT_A_CE_EVEN_N,
    output logic SLOT_A_CE_ODD_N,
    output logic [1:0] SCAN_PINS_4_5,
    output logic DMA_ACK_OUT_N,
    output logic GENERAL_PIN_0,
    output logic LCD_MODULATION_PIN,
    // decoded functions to internal blocks
    output logic [3:0] KEY_SHIFT_TO_SCANNER,
    output logic PRINTER_BUSY,
    output logic PRINTER_ERROR_N,
    output logic [1:0] KEY_RETURN_TO_SCANNER,
    output logic [1:0] SLOT_A_BATTERY_STATUS_OUT,
    output logic SLOT_A_SPEAKER_IN,
    output logic SLOT_A_STATUS_CHANGE,
    output logic [1:0] SLOT_B_BATTERY_STATUS,
    output logic SLOT_B_SPEAKER_IN,
    output logic SLOT_B_STATUS_CHANGE,
    output logic [1:0] SLOT_B_CARD_DETECT_N,
    output logic [2:0] DMA_REQUEST_INT,
    output logic SUSPEND_REQUEST
);

// ==========================================================
// configuration capture
logic scan_off;
logic a_io;
logic b_io;
logic lcd_off;
logic [1:0] dma_ch;
spfs_g0_t g0_sel;
spfs_g0_t next_g0_sel;
logic sw_prev;

always_comb begin
    case (GENERAL_PIN_0_SELECT)
        `SPFS_GENERAL_PIN_0_LCD: next_g0_sel = SPFS_G0_LCD;
        `SPFS_GENERAL_PIN_0_REFRESH: next_g0_sel = SPFS_G0_REFRESH;
        default: next_g0_sel = SPFS_G0_GPIO;
    endcase
end

// defaults hold until software moves a select
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        scan_off <= `SPFS_ZERO1;
    end else begin
        scan_off <= KEY_SCAN_DISABLE;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        a_io <= `SPFS_ZERO1;
    end else begin
        a_io <= SLOT_A_IO_MODE;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        b_io <= `SPFS_ZERO1;
    end else begin
        b_io <= SLOT_B_IO_MODE;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        lcd_off <= `SPFS_ZERO1;
    end else begin
        lcd_off <= LCD_DISABLE;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        g0_sel <= SPFS_G0_GPIO;
    end else begin
        g0_sel <= next_g0_sel;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        dma_ch <= `SPFS_DMA_CH_RESET;
    end else begin
        dma_ch <= DMA_CHANNEL_SELECT;
    end
end

// ==========================================================
// keyboard return and shift lines
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        PRINTER_BUSY <= `SPFS_ZERO1;
        PRINTER_ERROR_N <= `SPFS_ONE1;
        KEY_RETURN_TO_SCANNER <= 2'h0;
        KEY_SHIFT_TO_SCANNER <= 4'h0;
        SLOT_B_BATTERY_STATUS <= 2'h0;
        SLOT_B_SPEAKER_IN <= `SPFS_ONE1;
        SLOT_B_STATUS_CHANGE <= `SPFS_ZERO1;
        SLOT_B_CARD_DETECT_N <= `SPFS_ONES2;
    end else begin
        PRINTER_BUSY <= scan_off & KEY_RETURN_LINE_3;
        PRINTER_ERROR_N <= scan_off ? KEY_RETURN_LINE_7 : `SPFS_ONE1;
        KEY_RETURN_TO_SCANNER <= scan_off ? 2'h0 : {KEY_RETURN_LINE_7, KEY_RETURN_LINE_3};
        KEY_SHIFT_TO_SCANNER <= scan_off ? 4'h0 : KEY_SHIFT_LINES;
        // shift 1 carries bvd2, shift 2 carries bvd1
        SLOT_B_BATTERY_STATUS <= (scan_off & ~b_io) ?
            {KEY_SHIFT_LINES[1], KEY_SHIFT_LINES[2]} : 2'h0;
        SLOT_B_SPEAKER_IN <= (scan_off & b_io) ? KEY_SHIFT_LINES[1] : `SPFS_ONE1;
        SLOT_B_STATUS_CHANGE <= scan_off & b_io & KEY_SHIFT_LINES[2];
        SLOT_B_CARD_DETECT_N <= scan_off ?
            {KEY_SHIFT_LINES[3], KEY_SHIFT_LINES[0]} : `SPFS_ONES2;
    end
end
// shift 0 is not muxed here, so bit 0 of the shift bus carries shift 4

// ==========================================================
// slot A battery pins
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        SLOT_A_BATTERY_STATUS_OUT <= `SPFS_ZERO2;
    end else begin
        SLOT_A_BATTERY_STATUS_OUT <= a_io ? `SPFS_ZERO2 : SLOT_A_BATTERY_STATUS;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        SLOT_A_SPEAKER_IN <= `SPFS_ONE1;
    end else begin
        SLOT_A_SPEAKER_IN <= a_io ? SLOT_A_BATTERY_STATUS[1] : `SPFS_ONE1;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        SLOT_A_STATUS_CHANGE <= `SPFS_ZERO1;
    end else begin
        SLOT_A_STATUS_CHANGE <= a_io & SLOT_A_BATTERY_STATUS[0];
    end
end

// ==========================================================
// card strobes; one buffer pair serves both slots, byte lanes split even/odd
// 8-bit cards are steered onto the even (low) lane by the access logic
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        CARD_BUFFER_ENABLES_N_ODD <= `SPFS_ONE1;
        CARD_BUFFER_ENABLES_N_EVEN <= `SPFS_ONE1;
        CARD_BUFFER_DIRECTION <= `SPFS_ZERO1;
        SLOT_A_CE_EVEN_N <= `SPFS_ONE1;
        SLOT_A_CE_ODD_N <= `SPFS_ONE1;
    end else begin
        CARD_BUFFER_ENABLES_N_ODD <= ~(CARD_ACCESS & CARD_ODD_BYTE);
        CARD_BUFFER_ENABLES_N_EVEN <= ~(CARD_ACCESS & CARD_EVEN_BYTE);
        CARD_BUFFER_DIRECTION <= CARD_ACCESS & CARD_READ;
        SLOT_A_CE_EVEN_N <= ~(CARD_ACCESS & ~CARD_SLOT_B & CARD_EVEN_BYTE);
        SLOT_A_CE_ODD_N <= ~(CARD_ACCESS & ~CARD_SLOT_B & CARD_ODD_BYTE);
    end
end

// ==========================================================
// scan 4 is even select, scan 5 odd select when the scanner is off
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        SCAN_PINS_4_5 <= `SPFS_ZERO2;
    end else if (scan_off) begin
        SCAN_PINS_4_5 <= ~({CARD_ODD_BYTE, CARD_EVEN_BYTE}
            & {2{CARD_ACCESS & CARD_SLOT_B}});
    end else begin
        SCAN_PINS_4_5 <= KEY_SCAN_INT;
    end
end

// ==========================================================
// dma request and acknowledge routing
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        DMA_ACK_OUT_N <= `SPFS_ONE1;
        DMA_REQUEST_INT <= 3'h0;
    end else begin
        case (dma_ch)
            `SPFS_DMA_CH2: begin
                DMA_ACK_OUT_N <= DMA_ACK_INT_N[1];
                DMA_REQUEST_INT <= {1'h0, DMA_REQUEST_IN, 1'h0};
            end
            `SPFS_DMA_CH3: begin
                DMA_ACK_OUT_N <= DMA_ACK_INT_N[2];
                DMA_REQUEST_INT <= {DMA_REQUEST_IN, 2'h0};
            end
            default: begin
                // code 0 is unused and falls back to channel 1
                DMA_ACK_OUT_N <= DMA_ACK_INT_N[0];
                DMA_REQUEST_INT <= {2'h0, DMA_REQUEST_IN};
            end
        endcase
    end
end

// ==========================================================
// general pin 0 and lcd modulation pin
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        GENERAL_PIN_0 <= `SPFS_ZERO1;
    end else begin
        case (g0_sel)
            SPFS_G0_LCD: GENERAL_PIN_0 <= LCD_LOWER_DATA_0;
            SPFS_G0_REFRESH: GENERAL_PIN_0 <= REFRESH_ACK_N;
            default: GENERAL_PIN_0 <= GENERAL_PIN_0_OUT_INT;
        endcase
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        LCD_MODULATION_PIN <= `SPFS_ZERO1;
    end else begin
        LCD_MODULATION_PIN <= lcd_off ? REFRESH_ACK_N : LCD_MODULATION_INT;
    end
end

// ==========================================================
// suspend switch: rising edge is a one-cycle request
// sw_prev resets low, so a switch held high through reset still gives one request
always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        sw_prev <= `SPFS_ZERO1;
    end else begin
        sw_prev <= SUSPEND_SWITCH_IN;
    end
end

always_ff @(posedge CORE_CLK) begin
    if (RST) begin
        SUSPEND_REQUEST <= `SPFS_ZERO1;
    end else begin
        SUSPEND_REQUEST <= SUSPEND_SWITCH_IN & ~sw_prev;
    end
end

endmodule
`default_nettype wire

// ==== tb/spfs_far_side.sv ====
// Purpose: printer model on the far side of the shared return pins
// Assumes: the bench sets the printer status between clock edges
// Notes: the pins have no pull resistors, so the model always drives them
`timescale 1ns/10ps
`default_nettype none
module spfs_far_side (
    // printer status from the bench, {busy, error_n}
    input wire logic [1:0] status,
    // return line pins, {line 7, line 3}
    output logic [1:0] pins
);
    assign pins = {status[0], status[1]};
endmodule
`default_nettype wire

// ==== tb/spfs_pin_mux_asserts.sv ====
// Purpose: port checks for the shared pin function select block
// Assumes: a setting reaches the pins two cycles after it changes
// Notes: mode checks wait for three steady samples of the setting
`timescale 1ns/10ps
`default_nettype none
module spfs_pin_mux_asserts (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // watched inputs
    input wire logic KEY_SCAN_DISABLE,
    input wire logic KEY_RETURN_LINE_3,
    input wire logic KEY_RETURN_LINE_7,
    input wire logic DMA_REQUEST_IN,
    input wire logic SUSPEND_SWITCH_IN,
    // checked outputs
    input wire logic PRINTER_BUSY,
    input wire logic PRINTER_ERROR_N,
    input wire logic [1:0] SLOT_B_CARD_DETECT_N,
    input wire logic [2:0] DMA_REQUEST_INT,
    input wire logic SUSPEND_REQUEST
);
    // ==========
    // setting history, so a mode change still in flight is not judged
    logic [2:0] kh;
    logic [1:0] up;
    always_ff @(posedge CORE_CLK) kh <= {kh[1:0], KEY_SCAN_DISABLE};
    always_ff @(posedge CORE_CLK) up <= RST ? 2'h0 : up + {1'h0, up != 2'h3};
    wire logic on = up == 2'h3 && kh == 3'h7;
    wire logic off = up == 2'h3 && kh == 3'h0;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_busy_alt: assert property (on |-> PRINTER_BUSY == $past(KEY_RETURN_LINE_3))
        else $error("busy not following pin");
    a_busy_off: assert property (off |-> !PRINTER_BUSY) else $error("busy in scan mode");
    a_err_alt: assert property (on |-> PRINTER_ERROR_N == $past(KEY_RETURN_LINE_7))
        else $error("error not following pin");
    a_err_off: assert property (off |-> PRINTER_ERROR_N) else $error("error in scan mode");
    a_detect_off: assert property (off |-> SLOT_B_CARD_DETECT_N == 2'h3)
        else $error("slot b detect in scan mode");
    a_req_one: assert property (up == 2'h3 |-> $onehot0(DMA_REQUEST_INT))
        else $error("request on two channels");
    a_req_idle: assert property (up == 2'h3 && !$past(DMA_REQUEST_IN) |-> !DMA_REQUEST_INT)
        else $error("request without input");
    a_susp_pulse: assert property (SUSPEND_REQUEST |-> $past(SUSPEND_SWITCH_IN) ##1 !SUSPEND_REQUEST)
        else $error("suspend pulse wrong");
endmodule
`default_nettype wire

// ==== tb/spfs_pin_mux_test.sv ====
// Purpose: self-checking bench for the shared pin function select block
// Assumes: any setting reaches the pins within three cycles
// Notes: nets carry the port names, so the instance connects with .*
`timescale 1ns/10ps
`default_nettype none
module spfs_pin_mux_test;
    // ==========
    // pins, settings and helpers
    logic CORE_CLK = 1'h0, RST = 1'h1, GENERAL_PIN_0_OUT_INT, REFRESH_ACK_N, KEY_SCAN_DISABLE;
    logic SLOT_A_IO_MODE, SLOT_B_IO_MODE, LCD_DISABLE, CARD_ACCESS, CARD_SLOT_B, CARD_READ;
    logic CARD_EVEN_BYTE, CARD_ODD_BYTE, LCD_LOWER_DATA_0, LCD_MODULATION_INT, DMA_REQUEST_IN;
    logic SUSPEND_SWITCH_IN;
    logic [1:0] GENERAL_PIN_0_SELECT, DMA_CHANNEL_SELECT, KEY_SCAN_INT, SLOT_A_BATTERY_STATUS, printer;
    logic [2:0] DMA_ACK_INT_N;
    logic [3:0] KEY_SHIFT_LINES;
    wire logic KEY_RETURN_LINE_3, KEY_RETURN_LINE_7, CARD_BUFFER_ENABLES_N_ODD, GENERAL_PIN_0;
    wire logic CARD_BUFFER_ENABLES_N_EVEN, CARD_BUFFER_DIRECTION, SLOT_A_CE_EVEN_N;
    wire logic SLOT_A_CE_ODD_N, DMA_ACK_OUT_N, LCD_MODULATION_PIN, PRINTER_BUSY, PRINTER_ERROR_N;
    wire logic SLOT_A_SPEAKER_IN, SLOT_A_STATUS_CHANGE, SLOT_B_SPEAKER_IN, SLOT_B_STATUS_CHANGE;
    wire logic SUSPEND_REQUEST;
    wire logic [1:0] SCAN_PINS_4_5, KEY_RETURN_TO_SCANNER, SLOT_A_BATTERY_STATUS_OUT;
    wire logic [1:0] SLOT_B_BATTERY_STATUS, SLOT_B_CARD_DETECT_N;
    wire logic [2:0] DMA_REQUEST_INT;
    wire logic [3:0] KEY_SHIFT_TO_SCANNER;
    int compares = 0;
    int miscompares = 0;
    spfs_pin_mux spfs_pin_mux_inst (.*);
    spfs_far_side spfs_far_side_inst (.status(printer), .pins({KEY_RETURN_LINE_7, KEY_RETURN_LINE_3}));
    always #2.5 CORE_CLK = ~CORE_CLK;
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        if (got !== exp) miscompares++;
    endtask
    // outputs follow settings two cycles late, so three falling edges is safe
    task automatic settle();
        repeat (3) @(negedge CORE_CLK);
    endtask
    task automatic summarize();
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_refresh();
        for (int s = 0; s < 8; s++) begin
            GENERAL_PIN_0_SELECT = s[2:1];
            // gpio differs from lcd and refresh, so gpio is told apart from them; lcd and refresh carry the same value
            {GENERAL_PIN_0_OUT_INT, LCD_LOWER_DATA_0, REFRESH_ACK_N} = s[0] ? 3'h3 : 3'h4;
            settle();
            chk(GENERAL_PIN_0, s[2:1] == 2'h0 || s[2:1] == 2'h3 ? !s[0] : s[0]);
        end
        LCD_MODULATION_INT = 1'h1;
        settle();
        chk(LCD_MODULATION_PIN, 4'h1);
        REFRESH_ACK_N = 1'h0;
        LCD_DISABLE = 1'h1;
        settle();
        chk(LCD_MODULATION_PIN, 4'h0);
    endtask
    task automatic t_dma();
        logic [2:0] m;
        for (int c = 0; c < 4; c++) begin
            m = 3'h1 << (c == 0 ? 0 : c - 1);
            {DMA_CHANNEL_SELECT, DMA_REQUEST_IN, DMA_ACK_INT_N} = {c[1:0], 1'h1, ~m};
            settle();
            chk(DMA_REQUEST_INT, m);
            chk(DMA_ACK_OUT_N, 4'h0);
            DMA_ACK_INT_N = m;
            settle();
            chk(DMA_ACK_OUT_N, 4'h1);
        end
    endtask
    task automatic t_susp();
        int n = 0;
        SUSPEND_SWITCH_IN = 1'h1;
        repeat (6) begin
            @(negedge CORE_CLK);
            n += SUSPEND_REQUEST;
        end
        chk(n[3:0], 4'h1);
    endtask
    task automatic t_printer();
        {KEY_SHIFT_LINES, KEY_SCAN_INT} = 6'h26;
        settle();
        chk({PRINTER_BUSY, PRINTER_ERROR_N}, 4'h1);
        chk({KEY_RETURN_TO_SCANNER, SCAN_PINS_4_5}, 4'h6);
        chk(KEY_SHIFT_TO_SCANNER, 4'h9);
        KEY_SCAN_DISABLE = 1'h1;
        settle();
        chk({PRINTER_BUSY, PRINTER_ERROR_N}, 4'h2);
        chk({KEY_RETURN_TO_SCANNER, KEY_SHIFT_TO_SCANNER[1:0]}, 4'h0);
    endtask
    task automatic t_slots();
        {KEY_SHIFT_LINES, CARD_ACCESS, CARD_EVEN_BYTE, CARD_READ} = 7'h57;
        settle();
        chk({SLOT_B_BATTERY_STATUS, SLOT_B_CARD_DETECT_N}, 4'ha);
        chk(SLOT_A_BATTERY_STATUS_OUT, 4'h1);
        chk({SLOT_A_CE_ODD_N, SLOT_A_CE_EVEN_N, CARD_BUFFER_DIRECTION}, 4'h5);
        chk({CARD_BUFFER_ENABLES_N_ODD, CARD_BUFFER_ENABLES_N_EVEN}, 4'h2);
        {CARD_SLOT_B, CARD_READ, SLOT_A_IO_MODE, SLOT_B_IO_MODE} = 4'hb;
        settle();
        chk({SCAN_PINS_4_5, CARD_BUFFER_DIRECTION}, 4'h4);
        chk({SLOT_A_SPEAKER_IN, SLOT_A_STATUS_CHANGE}, 4'h1);
        chk({SLOT_B_SPEAKER_IN, SLOT_B_STATUS_CHANGE}, 4'h2);
    endtask
    initial begin
        {SLOT_A_IO_MODE, SLOT_B_IO_MODE, LCD_DISABLE, CARD_ACCESS, CARD_SLOT_B, CARD_READ} = 6'h0;
        {CARD_EVEN_BYTE, CARD_ODD_BYTE, LCD_LOWER_DATA_0, LCD_MODULATION_INT} = 4'h0;
        {DMA_REQUEST_IN, SUSPEND_SWITCH_IN, KEY_SCAN_DISABLE, GENERAL_PIN_0_SELECT, KEY_SCAN_INT} = 7'h0;
        {GENERAL_PIN_0_OUT_INT, REFRESH_ACK_N, DMA_CHANNEL_SELECT, DMA_ACK_INT_N} = 7'h6f;
        {SLOT_A_BATTERY_STATUS, printer, KEY_SHIFT_LINES} = 8'h60;
        repeat (20) @(negedge CORE_CLK);
        RST = 1'h0;
        settle();
        t_refresh();
        t_dma();
        t_susp();
        t_printer();
        t_slots();
        summarize();
    end
    // about four times the expected run, so a stuck wait cannot hang the run
    initial begin
        #2000;
        miscompares++;
        summarize();
    end
endmodule
bind spfs_pin_mux spfs_pin_mux_asserts spfs_pin_mux_asserts_inst (.*);
`default_nettype wire
